/* File: link_tx.sv */
// transmit transport layer, scrambler and link start for eight lanes
`timescale 1ns/1ps
`include "link_tx_regs.svh"
module link_tx (
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire link_tx_pkg::link_cfg_t CFG_I,
	input wire logic [63:0] SAMPLES_I,
	input wire logic SAMPLES_VALID_I,
	input wire logic SYSREF_I,
	input wire logic LINK_SYNC_INPUT_PIN_I,
	input wire logic LINK_RESTART_I,
	output link_tx_pkg::lane_out_t LANES_O,
	output logic LANES_VALID_O,
	output logic NCO_SYNC_O,
	output logic FEC_ACTIVE_O,
	output logic [1:0] LINK_STATE_O
);
	import link_tx_pkg::*;

	logic [1:0] sref_sync_reg;
	logic [1:0] sync_pin_reg;
	logic sref_prev_reg;
	logic sync_prev_reg;
	logic sysref_evt;
	logic sync_low;
	logic sync_rise;
	link_cfg_t cfg_prev_reg;
	logic restart;
	logic [7:0] frame_cnt_reg;
	logic [7:0] mf_cnt_reg;
	logic [1:0] ilas_cnt_reg;
	logic mf_edge;
	link_state_t state_reg;
	link_state_t state_next;
	logic [14:0] scr8_reg [`LANES_MAX];
	logic [57:0] scr66_reg [`LANES_MAX];
	logic [7:0] lane_mask;
	logic scr_on;
	// per-lane next values, gathered into one output register below
	logic [65:0] word_next [`LANES_MAX];
	logic k_next [`LANES_MAX];

	// pins are from outside the clock domain; first stage read by second only
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sref_sync_reg <= 2'b00;
			sync_pin_reg <= 2'b11;
			sref_prev_reg <= 1'b0;
			sync_prev_reg <= 1'b1;
		end else begin
			sref_sync_reg <= {sref_sync_reg[0], SYSREF_I};
			sync_pin_reg <= {sync_pin_reg[0], LINK_SYNC_INPUT_PIN_I};
			sref_prev_reg <= sref_sync_reg[1];
			sync_prev_reg <= sync_pin_reg[1];
		end
	end

	assign sysref_evt = sref_sync_reg[1] & ~sref_prev_reg;
	assign sync_low = ~sync_pin_reg[1];
	assign sync_rise = sync_pin_reg[1] & ~sync_prev_reg;

	// mode change counts as a restart
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cfg_prev_reg <= '0;
		end else begin
			cfg_prev_reg <= CFG_I;
		end
	end
	assign restart = LINK_RESTART_I | (cfg_prev_reg != CFG_I);

	// frame and multiframe / extended multiblock counters
	assign mf_edge = (frame_cnt_reg == `K_FRAMES);
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			frame_cnt_reg <= 8'h00;
			mf_cnt_reg <= 8'h00;
		end else if (sysref_evt || restart) begin
			// subclass 1 only: sysref aligns the phase
			frame_cnt_reg <= 8'h00;
			mf_cnt_reg <= 8'h00;
		end else if (mf_edge) begin
			frame_cnt_reg <= 8'h00;
			mf_cnt_reg <= (mf_cnt_reg == `E_MBLK) ? 8'h00 :
				mf_cnt_reg + 8'h01;
		end else begin
			frame_cnt_reg <= frame_cnt_reg + 8'h01;
		end
	end

	// link start state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (CFG_I.enc_64b66b) begin
					state_next = ST_DATA;
				end else if (sync_low) begin
					state_next = ST_CGS;
				end
			end
			ST_CGS: begin
				// receiver counts four commas, then releases sync
				if (sync_rise) begin
					state_next = ST_ILAS;
				end
			end
			ST_ILAS: begin
				if (sync_low) begin
					state_next = ST_CGS;
				end else if (mf_edge && ilas_cnt_reg == `ILAS_MF) begin
					state_next = ST_DATA;
				end
			end
			ST_DATA: begin
				if (!CFG_I.enc_64b66b && sync_low) begin
					state_next = ST_CGS;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_reg <= ST_IDLE;
		end else if (restart) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ilas waits for the next multiframe edge, then spans four multiframes
	logic ilas_started_reg;
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ilas_cnt_reg <= 2'd0;
			ilas_started_reg <= 1'b0;
		end else if (state_reg != ST_ILAS) begin
			ilas_cnt_reg <= 2'd0;
			ilas_started_reg <= 1'b0;
		end else if (mf_edge) begin
			if (ilas_started_reg) begin
				ilas_cnt_reg <= ilas_cnt_reg + 2'd1;
			end
			ilas_started_reg <= 1'b1;
		end
	end

	// lanes present depend on the variant; mode picks how many are used
	always_comb begin
		unique case (CFG_I.transport_mode_select)
			2'd0: lane_mask = 8'h01;
			2'd1: lane_mask = 8'h03;
			2'd2: lane_mask = 8'h0f;
			2'd3: lane_mask = 8'hff;
		endcase
		if (CFG_I.single_variant) begin
			lane_mask = lane_mask & 8'h0f;
		end
	end

	assign scr_on = CFG_I.enc_64b66b | CFG_I.scrambler_enable;

	// per-lane transport mapping and scrambling; one octet per lane word in 8b/10b, eight in 64b/66b
	// simplified mapping: each lane takes its own 8-bit slice of the sample bus, unpadded
	genvar g;
	generate
		for (g = 0; g < `LANES_MAX; g++) begin : g_lane
			logic [63:0] blk;
			logic [63:0] scr_blk;
			logic [7:0] oct;
			logic [7:0] scr_oct;
			logic [14:0] s8;
			logic [57:0] s66;
			// each lane carries one 8-bit slice of the samples per frame cycle
			assign blk = {SAMPLES_I[g*8 +: 8], SAMPLES_I[g*8 +: 8],
				SAMPLES_I[g*8 +: 8], SAMPLES_I[g*8 +: 8],
				SAMPLES_I[g*8 +: 8], SAMPLES_I[g*8 +: 8],
				SAMPLES_I[g*8 +: 8], SAMPLES_I[g*8 +: 8]};
			assign oct = SAMPLES_I[g*8 +: 8];
			// self-synchronous scramblers; polynomials differ
			always_comb begin
				s8 = scr8_reg[g];
				for (int b = 7; b >= 0; b--) begin
					scr_oct[b] = oct[b] ^ s8[`SCR8_T1] ^ s8[`SCR8_T2];
					s8 = {s8[13:0], scr_oct[b]};
				end
				s66 = scr66_reg[g];
				for (int b = 63; b >= 0; b--) begin
					scr_blk[b] = blk[b] ^ s66[`SCR66_T1] ^ s66[`SCR66_T2];
					s66 = {s66[56:0], scr_blk[b]};
				end
			end
			always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
				if (!NRST_I) begin
					scr8_reg[g] <= `SCR8_SEED;
					scr66_reg[g] <= '0;
				end else if (restart) begin
					scr8_reg[g] <= `SCR8_SEED;
					scr66_reg[g] <= '0;
				end else if (state_reg == ST_DATA && SAMPLES_VALID_I &&
					scr_on) begin
					scr8_reg[g] <= s8;
					scr66_reg[g] <= s66;
				end
			end
			always_comb begin
				word_next[g] = '0;
				k_next[g] = 1'b0;
				if (!lane_mask[g]) begin
					word_next[g] = '0;
				end else if (CFG_I.enc_64b66b) begin
					// header added after scrambling
					word_next[g] = {`SH_DATA, scr_blk};
				end else begin
					unique case (state_reg)
						ST_IDLE, ST_CGS: begin
							word_next[g] = {58'h0, `K28_5};
							k_next[g] = 1'b1;
						end
						ST_ILAS: begin
							if (!ilas_started_reg) begin
								// commas go on until the first multiframe edge
								word_next[g] = {58'h0, `K28_5};
								k_next[g] = 1'b1;
							end else begin
								// never scrambled
								word_next[g] = {58'h0, mf_edge ? `K28_3 :
									(frame_cnt_reg == 8'h00 ? `K28_0 : oct)};
								k_next[g] = mf_edge ||
									frame_cnt_reg == 8'h00;
							end
						end
						ST_DATA: begin
							word_next[g] = {58'h0,
								scr_on ? scr_oct : oct};
						end
					endcase
				end
			end
		end
	endgenerate

	// outputs; no 64b/80b, command channel or crc3 paths exist
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			LANES_O <= '0;
			LANES_VALID_O <= 1'b0;
			NCO_SYNC_O <= 1'b0;
			FEC_ACTIVE_O <= 1'b0;
			LINK_STATE_O <= 2'b00;
		end else begin
			// one process owns the whole lane struct
			for (int i = 0; i < `LANES_MAX; i++) begin
				LANES_O.word[i] <= word_next[i];
				LANES_O.charisk[i] <= k_next[i];
			end
			LANES_O.lane_en <= lane_mask;
			LANES_VALID_O <= (state_reg == ST_DATA) ? SAMPLES_VALID_I : 1'b1;
			NCO_SYNC_O <= CFG_I.enc_64b66b & CFG_I.sync_for_nco & sync_low;
			FEC_ACTIVE_O <= CFG_I.enc_64b66b & CFG_I.fec_enable;
			LINK_STATE_O <= state_reg;
		end
	end
endmodule

/* File: link_tx_regs.svh */
// constants and functional notes for the transmit transport and scrambler
// Functional notes
// - lanes run 8b/10b or 64b/66b line coding, chosen by configuration.
// - up to eight serial lanes may be used to lower per-lane rate.
// - large variants drive eight lanes; the single variant drives four.
// - 64b/66b block sync uses the embedded sync header, not the handshake.
// - in 64b/66b the sync input is ignored for link start, kept for nco.
// - sysref resets the multiframe counter (8b/10b) or extended multiblock.
// - the device clock runs the digital logic and the serializer side.
// - forward error correction is offered with the 64b/66b link layer.
// - no 64b/80b, no command channel, no three-bit crc.
// - subclass 1 only; still works with a subclass 0 receiver.
// - lane alignment within one link; no multipoint reference.
// - 8b/10b sync pin timing follows both earlier standard revisions.
// - samples pack into octets, f octets form a frame, spread over l lanes.
// - n-bit samples sent as n-prime fields; s samples from m converters; here each lane sends its own 8-bit sample slice as is.
// - one transport mode setting picks lanes, converters, octets per frame; here it sets the lane count only.
// - 8b/10b scrambles only when enabled; 64b/66b always scrambles.
// - scrambling acts on octets or 64-bit blocks before coding.
// - the 8b/10b lane alignment sequence is never scrambled.
// - polynomials differ by coding; receiver self-synchronizes descrambler.
// - frames group into multiframes, or blocks and extended multiblocks.
// - in 8b/10b, sync low makes every enabled lane send continuous k28.5 commas.
`ifndef LINK_TX_REGS_SVH
`define LINK_TX_REGS_SVH
`define LANES_MAX 8
`define LANES_SINGLE 4
`define OCT_W 8
`define BLK_W 64
`define MODE_W 2
`define K_FRAMES 8'd31
`define E_MBLK 8'd31
`define ILAS_MF 2'd3
`define K28_5 8'hbc
`define K28_0 8'h1c
`define K28_3 8'h7c
`define K28_7 8'hfc
`define SH_DATA 2'b01
`define SH_CMD 2'b10
`define SCR8_SEED 15'h7f80
`define SCR8_T1 14
`define SCR8_T2 13
`define SCR66_T1 38
`define SCR66_T2 57
`endif

/* File: link_tx_pkg.sv */
// types for the transmit transport and scrambler
package link_tx_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CGS = 2'b01,
		ST_ILAS = 2'b10,
		ST_DATA = 2'b11
	} link_state_t;
	typedef struct packed {
		logic enc_64b66b;
		logic scrambler_enable;
		logic fec_enable;
		logic sync_for_nco;
		logic single_variant;
		logic [1:0] transport_mode_select;
	} link_cfg_t;
	typedef struct packed {
		logic [7:0][65:0] word;
		logic [7:0] charisk;
		logic [7:0] lane_en;
	} lane_out_t;
endpackage

/* File: link_tx_props.sv */
// assertion checker for the transmit link block
`timescale 1ns/1ps
module link_tx_props
	import link_tx_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire link_tx_pkg::link_cfg_t CFG_I,
	input wire logic LINK_RESTART_I,
	input wire link_tx_pkg::lane_out_t LANES_O,
	input wire logic NCO_SYNC_O,
	input wire logic FEC_ACTIVE_O,
	input wire logic [1:0] LINK_STATE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);
	// config needs a few cycles to settle after a change
	sequence cfg64_s;
		CFG_I.enc_64b66b [*5];
	endsequence
	sequence ilas_go_s;
		$rose(LINK_STATE_O == 2'h2);
	endsequence
	cgs_comma_a: assert property (LINK_STATE_O == 2'h1 |->
		LANES_O.word[0][7:0] == 8'hbc && LANES_O.charisk[0])
		else $error("no comma in cgs");
	sequence ilas_end_mf_s;
		LINK_STATE_O == 2'h2 && LANES_O.charisk[0] &&
			LANES_O.word[0][7:0] == 8'h7c;
	endsequence
	ilas_start_a: assert property (ilas_go_s |->
		LANES_O.word[0][7:0] == 8'hbc && LANES_O.charisk[0])
		else $error("ilas wait does not hold commas");
	ilas_wrap_a: assert property (ilas_end_mf_s ##1 LINK_STATE_O == 2'h2
		|-> LANES_O.word[0][7:0] == 8'h1c && LANES_O.charisk[0])
		else $error("ilas multiframe does not open with start char");
	sync_ignored_a: assert property (cfg64_s |-> LINK_STATE_O != 2'h1)
		else $error("cgs entered in 64b66b");
	sync_header_a: assert property (cfg64_s ##0 LINK_STATE_O == 2'h3 |->
		LANES_O.word[0][65:64] == 2'b01)
		else $error("bad sync header");
	lane_off_a: assert property (!LANES_O.lane_en[7] |->
		LANES_O.word[7] == '0 && !LANES_O.charisk[7])
		else $error("masked lane not quiet");
	single_clamp_a: assert property (CFG_I.single_variant [*3] |->
		LANES_O.lane_en[7:4] == 4'h0)
		else $error("single variant uses upper lanes");
	fec_on_a: assert property ((CFG_I.enc_64b66b && CFG_I.fec_enable) [*3]
		|-> FEC_ACTIVE_O)
		else $error("fec not active");
	fec_off_a: assert property (!CFG_I.enc_64b66b [*3] |-> !FEC_ACTIVE_O)
		else $error("fec active in 8b10b");
	nco_off_a: assert property (!CFG_I.sync_for_nco [*5] |-> !NCO_SYNC_O)
		else $error("nco sync without enable");
	restart_idle_a: assert property (LINK_RESTART_I && !CFG_I.enc_64b66b
		|-> ##2 LINK_STATE_O == 2'h0)
		else $error("restart did not idle link");
endmodule
bind link_tx link_tx_props link_tx_props_inst (
	.CORE_CLK_I(CORE_CLK_I),
	.NRST_I(NRST_I),
	.CFG_I(CFG_I),
	.LINK_RESTART_I(LINK_RESTART_I),
	.LANES_O(LANES_O),
	.NCO_SYNC_O(NCO_SYNC_O),
	.FEC_ACTIVE_O(FEC_ACTIVE_O),
	.LINK_STATE_O(LINK_STATE_O)
);

/* File: link_rx_model.sv */
// receiver model: requests link start and counts lane 0 commas
`timescale 1ns/1ps
module link_rx_model
	import link_tx_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ready_i,
	input wire link_tx_pkg::lane_out_t lanes_i,
	output logic sync_n_o
);
	logic [2:0] comma_reg;
	// no local multiframe clock here: release comes right after the fourth comma
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			comma_reg <= 3'h0;
			sync_n_o <= 1'b1;
		end else if (!ready_i) begin
			comma_reg <= 3'h0;
			sync_n_o <= 1'b1;
		end else if (comma_reg == 3'h4) begin
			sync_n_o <= 1'b1;
		end else begin
			sync_n_o <= 1'b0;
			if (!sync_n_o && lanes_i.charisk[0] && lanes_i.word[0][7:0] == 8'hbc)
				comma_reg <= comma_reg + 3'h1;
			else
				comma_reg <= 3'h0;
		end
	end
endmodule

/* File: link_tx_tb.sv */
// self-checking bench for the transmit link block
`timescale 1ns/1ps
module link_tx_tb;
	import link_tx_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	link_cfg_t cfg = '0;
	logic [63:0] samples = 64'h0;
	logic valid = 1'b0;
	logic sysref = 1'b0;
	logic restart = 1'b0;
	logic ready = 1'b0;
	logic sync_n, lanes_valid, nco, fec;
	lane_out_t lanes;
	logic [1:0] state;
	int miscompares = 0;
	int cmp_count = 0;
	int m;
	always #5 clk = ~clk;
	link_tx link_tx_inst (
		.CORE_CLK_I(clk),
		.NRST_I(nrst),
		.CFG_I(cfg),
		.SAMPLES_I(samples),
		.SAMPLES_VALID_I(valid),
		.SYSREF_I(sysref),
		.LINK_SYNC_INPUT_PIN_I(sync_n),
		.LINK_RESTART_I(restart),
		.LANES_O(lanes),
		.LANES_VALID_O(lanes_valid),
		.NCO_SYNC_O(nco),
		.FEC_ACTIVE_O(fec),
		.LINK_STATE_O(state)
	);
	link_rx_model link_rx_model_inst (
		.clk_i(clk),
		.nrst_i(nrst),
		.ready_i(ready),
		.lanes_i(lanes),
		.sync_n_o(sync_n)
	);
	task automatic stop_test();
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_state(input logic [1:0] s);
		int i;
		for (i = 0; i < 400 && state !== s; i++) @(negedge clk);
		cmp({6'h0, state}, {6'h0, s});
		if (state !== s) stop_test();
	endtask
	// ready dropped for a cycle, then set to r; with r high the receiver asks again
	task automatic go(input logic [6:0] c, input logic r);
		@(posedge clk);
		cfg <= link_cfg_t'(c);
		ready <= 1'b0;
		@(posedge clk);
		ready <= r;
		repeat (4) @(posedge clk);
	endtask
	task automatic vary(input logic exp);
		logic [15:0] a;
		@(negedge clk);
		a = {lanes.word[1][7:0], lanes.word[0][7:0]};
		@(negedge clk);
		cmp({7'h0, a != {lanes.word[1][7:0], lanes.word[0][7:0]}}, {7'h0, exp});
	endtask
	task automatic link_8b();
		go(7'h03, 1'b1);
		wait_state(2'h1);
		wait_state(2'h3);
		vary(1'b0);
		go(7'h23, 1'b1);
		wait_state(2'h3);
		vary(1'b1);
	endtask
	task automatic restart_8b();
		@(posedge clk);
		sysref <= 1'b1;
		restart <= 1'b1;
		ready <= 1'b0;
		@(posedge clk);
		sysref <= 1'b0;
		restart <= 1'b0;
		ready <= 1'b1;
		wait_state(2'h1);
		wait_state(2'h3);
	endtask
	task automatic link_64();
		go(7'h43, 1'b0);
		wait_state(2'h3);
		vary(1'b1);
		cmp({7'h0, fec}, 8'h00);
		go(7'h5b, 1'b1);
		repeat (4) @(negedge clk);
		cmp({6'h0, nco, fec}, 8'h03);
		cmp({6'h0, state}, 8'h03);
	endtask
	task automatic modes();
		for (m = 0; m < 4; m++) begin
			go(7'h40 | 7'(m), 1'b0);
			wait_state(2'h3);
			cmp(lanes.lane_en, 8'((1 << (1 << m)) - 1));
		end
		go(7'h47, 1'b0);
		wait_state(2'h3);
		cmp(lanes.lane_en, 8'h0f);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		samples <= 64'h3c3c3c3c3c3c3c3c;
		valid <= 1'b1;
		link_8b();
		restart_8b();
		link_64();
		modes();
		stop_test();
	end
endmodule
